// ===== eerd_pkg.sv
// constants of the serial eeprom read path
// assumes a single system clock that samples the two-wire bus pins
//
// How it works
// - no select ack until write cycle ends
// - every array byte starts as all ones
// - counter steps once per byte read out
// - current read: select, ack, byte, nack, stop
// - random read: dummy write loads address, restart
// - after restart, read select returns addressed byte
// - master ack fetches next consecutive byte
// - counter wraps past top address to zero
// - no ack in ninth slot means standby
// - select byte: type nibble, three ignored, direction
// - direction bit one reads, zero writes
// - sda bits sampled on scl rise; start and stop seen while scl high
// - write select then address byte loads counter
package eerd_pkg;

  // ----------------------------------------
  // array geometry
  // ----------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int MEM_WORDS = 128;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ----------------------------------------
  // select byte layout, msb first on the wire
  // ----------------------------------------
  localparam int SEL_TYPE_HI = 7;
  localparam int SEL_TYPE_LO = 4;
  localparam int SEL_DIR_BIT = 0;
  localparam logic SEL_DIR_READ = 1'b1;
  // device type value is arbitrary here
  localparam logic [3:0] SEL_TYPE_DEFAULT = 4'h5;

  // ----------------------------------------
  // bit slot counts and buffering
  // ----------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------
  // protocol states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_ADDR,
    ST_WDAT,
    ST_TX,
    ST_MACK
  } eerd_state_e;

endpackage

// ===== eerd_stream_if.sv
// valid/ready byte stream between the fetch logic and its buffer
// assumes both ends share sys_clk_i
`timescale 1ns/1ps
interface eerd_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;

  // producer side
  modport src (output data, output valid, input ready);
  // consumer side
  modport snk (input data, input valid, output ready);
endinterface

// ===== eerd_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module eerd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // fill and drain sides
  eerd_stream_if.snk in_if,
  eerd_stream_if.src out_if
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0] wr_ptr_r;
  logic [PW:0] rd_ptr_r;
  logic [WIDTH-1:0] head_r;

  // ----------------------------------------
  // status and handshakes
  // ----------------------------------------
  wire logic empty = (wr_ptr_r == rd_ptr_r);
  wire logic full = (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]) &&
                    (wr_ptr_r[PW] != rd_ptr_r[PW]);
  wire logic push = in_if.valid && !full;
  wire logic pop = out_if.ready && !empty;

  assign in_if.ready = !full;
  assign out_if.valid = !empty;
  assign out_if.data = head_r;

  // storage write
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      mem_r[wr_ptr_r[PW-1:0]] <= in_if.data;
  end

  // head word, combinational read of the oldest entry
  always_comb
  begin
    head_r = mem_r[rd_ptr_r[PW-1:0]];
  end

  // pointers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

endmodule

// ===== eerd_read_path.sv
// two-wire serial eeprom slave with its read path
// assumes scl and sda arrive asynchronously; sda is open drain
// assumes an outside write path drives the array write port and busy flag
`timescale 1ns/1ps
module eerd_read_path #(
  parameter logic [3:0] SEL_TYPE = eerd_pkg::SEL_TYPE_DEFAULT,
  parameter int FIFO_DEPTH = eerd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // outside write path
  input wire logic write_busy_i,
  input wire logic mem_we_i,
  input wire logic [eerd_pkg::ADDR_W-1:0] mem_waddr_i,
  input wire logic [eerd_pkg::DATA_W-1:0] mem_wdata_i,
  // status
  output logic [eerd_pkg::ADDR_W-1:0] cur_addr_o,
  output logic busy_o
);

  localparam int AW = eerd_pkg::ADDR_W;
  localparam int DW = eerd_pkg::DATA_W;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic scl_f_r;
  logic sda_f_r;
  eerd_pkg::eerd_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [DW-1:0] shift_r;
  logic ack_r;
  logic rw_r;
  logic mack_ok_r;
  logic fetch_req_r;
  logic oe_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] mem_r [eerd_pkg::MEM_WORDS];

  eerd_stream_if #(.WIDTH(DW)) fetch_if ();
  eerd_stream_if #(.WIDTH(DW)) tx_if ();

  // ----------------------------------------
  // pin synchronisers and filtered levels
  // ----------------------------------------
  // a change counts once the second and third stage agree
  wire logic scl_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
  wire logic sda_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end
    else
    begin
      scl_s_r <= {scl_s_r[1:0], scl_i};
      sda_s_r <= {sda_s_r[1:0], sda_i};
      scl_f_r <= scl_nxt;
      sda_f_r <= sda_nxt;
    end
  end

  // ----------------------------------------
  // bus events
  // ----------------------------------------
  wire logic scl_rise = !scl_f_r && scl_nxt;
  wire logic scl_fall = scl_f_r && !scl_nxt;
  wire logic scl_hi = scl_f_r && scl_nxt;
  wire logic bus_start = scl_hi && sda_f_r && !sda_nxt;
  wire logic bus_stop = scl_hi && !sda_f_r && sda_nxt;

  // ----------------------------------------
  // select byte decode
  // ----------------------------------------
  wire logic type_hit =
    (shift_r[eerd_pkg::SEL_TYPE_HI:eerd_pkg::SEL_TYPE_LO] == SEL_TYPE);
  wire logic sel_is_read = (shift_r[eerd_pkg::SEL_DIR_BIT] == eerd_pkg::SEL_DIR_READ);
  wire logic sel_ok = type_hit && !write_busy_i;
  wire logic rx_state = (state_r == eerd_pkg::ST_SEL) || (state_r == eerd_pkg::ST_ADDR) ||
                        (state_r == eerd_pkg::ST_WDAT);
  wire logic byte_in = (bit_cnt_r == eerd_pkg::BITS_PER_BYTE);
  wire logic ack_decide = rx_state && scl_fall && byte_in && !ack_r;
  wire logic ack_done = rx_state && scl_fall && byte_in && ack_r;
  wire logic ack_grant = (state_r == eerd_pkg::ST_SEL) ? sel_ok : 1'b1;
  wire logic start_read = ack_decide && (state_r == eerd_pkg::ST_SEL) && sel_ok && sel_is_read;
  wire logic mack_seen = (state_r == eerd_pkg::ST_MACK) && scl_rise;
  wire logic tx_load = (ack_done && rw_r && (state_r == eerd_pkg::ST_SEL)) ||
                       ((state_r == eerd_pkg::ST_MACK) && scl_fall && mack_ok_r);
  wire logic tx_shift = (state_r == eerd_pkg::ST_TX) && scl_fall;

  // ----------------------------------------
  // protocol state machine
  // ----------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= eerd_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      ack_r <= 1'b0;
      rw_r <= 1'b0;
      mack_ok_r <= 1'b0;
    end
    else if (bus_start)
    begin
      state_r <= eerd_pkg::ST_SEL;
      bit_cnt_r <= 4'h0;
      ack_r <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_r <= eerd_pkg::ST_IDLE;
      ack_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        eerd_pkg::ST_SEL, eerd_pkg::ST_ADDR, eerd_pkg::ST_WDAT:
        begin
          if (scl_rise && !byte_in)
            bit_cnt_r <= bit_cnt_r + 4'h1;
          if (ack_decide)
          begin
            ack_r <= ack_grant;
            rw_r <= sel_is_read;
            if (!ack_grant)
              state_r <= eerd_pkg::ST_IDLE;
          end
          else if (ack_done)
          begin
            ack_r <= 1'b0;
            bit_cnt_r <= 4'h0;
            if (state_r == eerd_pkg::ST_SEL)
              state_r <= rw_r ? eerd_pkg::ST_TX : eerd_pkg::ST_ADDR;
            else
              state_r <= eerd_pkg::ST_WDAT;
          end
        end
        eerd_pkg::ST_TX:
        begin
          if (tx_shift)
          begin
            if (bit_cnt_r == eerd_pkg::LAST_TX_BIT)
            begin
              state_r <= eerd_pkg::ST_MACK;
              bit_cnt_r <= 4'h0;
            end
            else
              bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        eerd_pkg::ST_MACK:
        begin
          if (mack_seen)
          begin
            mack_ok_r <= !sda_nxt;
            if (sda_nxt)
              state_r <= eerd_pkg::ST_IDLE;
          end
          else if (scl_fall)
            state_r <= eerd_pkg::ST_TX;
        end
        default:
        begin
          bit_cnt_r <= 4'h0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // receive and transmit shifter
  // ----------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      shift_r <= eerd_pkg::ERASED_BYTE;
    else if (tx_load)
      shift_r <= tx_if.data;
    else if (tx_shift)
      shift_r <= {shift_r[DW-2:0], 1'b1};
    else if (rx_state && scl_rise && !byte_in)
      shift_r <= {shift_r[DW-2:0], sda_nxt};
  end

  // ----------------------------------------
  // byte address counter and fetch request
  // ----------------------------------------
  wire logic fetch_push = fetch_req_r && fetch_if.ready;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      addr_r <= '0;
      fetch_req_r <= 1'b0;
    end
    else
    begin
      if (ack_decide && (state_r == eerd_pkg::ST_ADDR))
        addr_r <= shift_r[AW-1:0];
      else if (fetch_push)
        addr_r <= addr_r + 1'b1;
      if (start_read || (mack_seen && !sda_nxt))
        fetch_req_r <= 1'b1;
      else if (fetch_push)
        fetch_req_r <= 1'b0;
    end
  end

  assign fetch_if.valid = fetch_req_r;
  assign fetch_if.data = mem_r[addr_r];
  assign tx_if.ready = tx_load;

  // ----------------------------------------
  // memory array, one entry per generate step
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < eerd_pkg::MEM_WORDS; gi++)
    begin : g_word
      always_ff @(posedge sys_clk_i)
      begin
        if (!rst_n_i)
          mem_r[gi] <= eerd_pkg::ERASED_BYTE;
        else if (mem_we_i && (mem_waddr_i == AW'(gi)))
          mem_r[gi] <= mem_wdata_i;
      end
    end
  endgenerate

  // ----------------------------------------
  // byte buffer between array and shifter
  // ----------------------------------------
  eerd_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_if(fetch_if),
    .out_if(tx_if)
  );

  // ----------------------------------------
  // sda drive, changes only after scl falls
  // ----------------------------------------
  wire logic oe_nxt = ack_r || ((state_r == eerd_pkg::ST_TX) && !shift_r[DW-1]);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      oe_r <= 1'b0;
    else
      oe_r <= oe_nxt;
  end

  assign sda_o = 1'b0; // open drain: only ever pulls low
  assign sda_oe_o = oe_r;
  assign cur_addr_o = addr_r;
  assign busy_o = (state_r != eerd_pkg::ST_IDLE);

endmodule

// ===== eerd_read_path_properties.sv
// checker on the read path ports
// assumes bind onto eerd_read_path, one clock
`timescale 1ns/1ps
module eerd_read_path_properties (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // status
  input wire logic write_busy_i,
  input wire logic [eerd_pkg::ADDR_W-1:0] cur_addr_o,
  input wire logic busy_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [5:0] wb_cnt_r;
  // ----------------------------------------
  // write cycle length, saturating
  // ----------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || !write_busy_i)
      wb_cnt_r <= 6'h00;
    else if (wb_cnt_r != 6'h3f)
      wb_cnt_r <= wb_cnt_r + 6'h01;
  end
  // bus start and stop on the pins
  sequence start_s;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence
  sequence stop_s;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  a_pin_value_low: assert property (sda_oe_o |-> (sda_o == 1'b0) && !sda_i)
    else $error("sda not pulled low while driven");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda drive changed with scl high");
  a_drive_holds: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("sda drive too short");
  a_idle_quiet: assert property (!busy_o |-> !sda_oe_o)
    else $error("sda driven while idle");
  a_start_wakes: assert property (start_s |-> ##[1:8] busy_o)
    else $error("start not seen");
  a_stop_idles: assert property (stop_s |-> ##[1:8] !busy_o)
    else $error("stop not seen");
  a_addr_moves: assert property ($changed(cur_addr_o) |-> busy_o || $past(busy_o))
    else $error("counter moved while idle");
  a_poll_refused: assert property (wb_cnt_r == 6'h3f |-> !sda_oe_o)
    else $error("ack during write cycle");
endmodule
bind eerd_read_path eerd_read_path_properties eerd_read_path_properties_i (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .write_busy_i(write_busy_i),
  .cur_addr_o(cur_addr_o),
  .busy_o(busy_o)
);

// ===== eerd_bus_master.sv
// two-wire bus master model
// assumes a pull-up on sda: released reads high
`timescale 1ns/1ps
module eerd_bus_master (
  // clock
  input wire logic sys_clk_i,
  // bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // ----------------------------------------
  // bus tasks, scl stands high between frames
  // ----------------------------------------
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // start or repeated start
  task automatic start();
    sda_o = 1'b1;
    wt(10);
    scl_o = 1'b1;
    wt(10);
    sda_o = 1'b0;
    wt(10);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    wt(10);
    scl_o = 1'b1;
    wt(10);
    sda_o = 1'b1;
    wt(10);
  endtask
  // data set while scl low, sampled in scl high
  task automatic bit_slot(input logic b, output logic r);
    sda_o = b;
    wt(10);
    scl_o = 1'b1;
    wt(5);
    r = sda_i;
    wt(5);
    scl_o = 1'b0;
  endtask
  // eight bits msb first, then the ack slot
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--)
      bit_slot(d[i], q[i]);
    bit_slot(ak, a);
  endtask
endmodule

// ===== eerd_read_path_tb_top.sv
// bench for the eeprom read path
// assumes the master model drives scl and its share of sda
`timescale 1ns/1ps
module eerd_read_path_tb_top;
  localparam logic [3:0] ty = eerd_pkg::SEL_TYPE_DEFAULT;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic write_busy_i = 1'b0;
  logic mem_we_i = 1'b0;
  logic [6:0] mem_waddr_i = 7'h00;
  logic [7:0] mem_wdata_i = 8'h00;
  logic scl;
  logic sda_m;
  logic sda_o;
  logic sda_oe;
  logic busy;
  logic [6:0] cur_addr;
  logic [7:0] q;
  logic a;
  int fail_count = 0;
  int checks = 0;
  wire sda_line = sda_m & (sda_oe ? sda_o : 1'b1);
  always #12.5 sys_clk_i = ~sys_clk_i;
  eerd_read_path eerd_read_path_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .write_busy_i(write_busy_i), .mem_we_i(mem_we_i), .mem_waddr_i(mem_waddr_i),
    .mem_wdata_i(mem_wdata_i), .cur_addr_o(cur_addr), .busy_o(busy));
  eerd_bus_master eerd_bus_master_i (.sys_clk_i(sys_clk_i), .sda_i(sda_line),
    .scl_o(scl), .sda_o(sda_m));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // select byte with ignored bits set to 101
  function automatic logic [7:0] sel(input logic [3:0] t, input logic rw);
    return {t, 3'h5, rw};
  endfunction
  task automatic poke(input logic [6:0] ad, input logic [7:0] d);
    @(negedge sys_clk_i);
    mem_waddr_i = ad;
    mem_wdata_i = d;
    mem_we_i = 1'b1;
    @(negedge sys_clk_i);
    mem_we_i = 1'b0;
  endtask
  task automatic go(input logic [7:0] b, input logic e);
    eerd_bus_master_i.start();
    eerd_bus_master_i.xfer(b, 1'b1, q, a);
    chk({7'h00, a}, {7'h00, e});
  endtask
  // dummy write of the address, restart, read select
  task automatic aim(input logic [6:0] ad);
    go(sel(ty, 1'b0), 1'b0);
    eerd_bus_master_i.xfer({1'b0, ad}, 1'b1, q, a);
    chk({7'h00, a}, 8'h00);
    go(sel(ty, 1'b1), 1'b0);
  endtask
  task automatic rd(input logic ak, input logic [7:0] e);
    eerd_bus_master_i.xfer(8'hff, ak, q, a);
    chk(q, e);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_current();
    poke(7'h01, 8'h00);
    chk({1'b0, cur_addr}, 8'h00);
    go(sel(ty, 1'b1), 1'b0);
    rd(1'b1, 8'hff);
    rd(1'b1, 8'hff);
    eerd_bus_master_i.stop();
    chk({1'b0, cur_addr}, 8'h01);
    $display("current read done");
  endtask
  task automatic t_random();
    poke(7'h05, 8'h5a);
    poke(7'h06, 8'ha5);
    aim(7'h05);
    rd(1'b0, 8'h5a);
    rd(1'b1, 8'ha5);
    eerd_bus_master_i.stop();
    chk({1'b0, cur_addr}, 8'h07);
    $display("random read done");
  endtask
  task automatic t_wrap();
    poke(7'h7f, 8'h3c);
    poke(7'h00, 8'hc3);
    aim(7'h7f);
    rd(1'b0, 8'h3c);
    rd(1'b1, 8'hc3);
    eerd_bus_master_i.stop();
    chk({1'b0, cur_addr}, 8'h01);
    $display("wrap read done");
  endtask
  task automatic t_refuse();
    go(sel(ty ^ 4'h3, 1'b1), 1'b1);
    eerd_bus_master_i.stop();
    write_busy_i = 1'b1;
    go(sel(ty, 1'b1), 1'b1);
    eerd_bus_master_i.stop();
    write_busy_i = 1'b0;
    go(sel(ty, 1'b1) ^ 8'h06, 1'b0);
    rd(1'b1, 8'h00);
    eerd_bus_master_i.stop();
    chk({7'h00, busy}, 8'h00);
    $display("refusal done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    t_current();
    t_random();
    t_wrap();
    t_refuse();
    stop_test();
  end
  initial
  begin
    #500000;
    fail_count++;
    stop_test();
  end
endmodule
